// file: fhc_pkg.sv
// Package: constants, register map and carrier types of the flash host controller
package fhc_pkg;
    // Register byte offsets on the AHB-Lite slave
    localparam logic [7:0] FHC_REG_CTRL   = 8'h00;
    localparam logic [7:0] FHC_REG_ADDR   = 8'h04;
    localparam logic [7:0] FHC_REG_WDATA  = 8'h08;
    localparam logic [7:0] FHC_REG_RDATA  = 8'h0C;
    localparam logic [7:0] FHC_REG_STATUS = 8'h10;
    localparam logic [7:0] FHC_REG_IRQ    = 8'h14;
    localparam logic [7:0] FHC_REG_MASK   = 8'h18;
    localparam logic [7:0] FHC_REG_CFG    = 8'h1C;

    // CTRL fields (write one to start)
    localparam int FHC_CTRL_WRITE   = 0;
    localparam int FHC_CTRL_READ    = 1;
    localparam int FHC_CTRL_CLEAR   = 2;
    localparam int FHC_CTRL_POLL    = 3;
    localparam int FHC_CTRL_UNPROT  = 4;
    // CFG fields
    localparam int FHC_CFG_WORD     = 0;
    localparam int FHC_CFG_CE_TOG   = 1;
    localparam int FHC_CFG_UNPROT   = 2;
    // STATUS fields
    localparam int FHC_ST_BUSY      = 0;
    localparam int FHC_ST_DEV_BUSY  = 1;
    localparam int FHC_ST_POLL_FAIL = 2;
    // IRQ event bits
    localparam int FHC_EV_DONE      = 0;
    localparam int FHC_EV_POLL_OK   = 1;
    localparam int FHC_EV_READY     = 2;
    localparam int FHC_NUM_EV       = 3;

    // Reset values
    localparam logic [2:0]  FHC_CFG_RESET  = 3'h1;
    localparam logic [2:0]  FHC_MASK_RESET = 3'h0;

    // Clock and times (ns) with derived cycle counts
    localparam int FHC_CLK_NS        = 5;
    localparam int FHC_T_CYCLE_NS    = 150;   // slowest write and read cycle
    localparam int FHC_T_WPH_NS      = 20;    // strobe high between pulses
    localparam int FHC_T_WP_NS       = 50;    // slowest write pulse width
    localparam int FHC_T_RP_NS       = 500;   // clear pulse width
    localparam int FHC_T_RH_NS       = 50;    // clear high before read
    localparam int FHC_T_RDY_IDLE_NS = 500;
    localparam int FHC_T_RDY_ALG_NS  = 20000;
    localparam int FHC_T_RSP_NS      = 4000;  // elevated level before write
    localparam int FHC_T_BUSY_NS     = 55;    // slowest busy assertion delay
    localparam int FHC_T_ACC_NS      = 150;   // slowest word-mode access

    localparam int FHC_CYC_CYCLE = (FHC_T_CYCLE_NS + FHC_CLK_NS - 1) / FHC_CLK_NS;
    localparam int FHC_CYC_WPH   = (FHC_T_WPH_NS + FHC_CLK_NS - 1) / FHC_CLK_NS;
    localparam int FHC_CYC_WP    = (FHC_T_WP_NS + FHC_CLK_NS - 1) / FHC_CLK_NS;
    localparam int FHC_CYC_RP    = (FHC_T_RP_NS + FHC_CLK_NS - 1) / FHC_CLK_NS;
    localparam int FHC_CYC_RH    = (FHC_T_RH_NS + FHC_CLK_NS - 1) / FHC_CLK_NS;
    localparam int FHC_CYC_RDY_I = (FHC_T_RDY_IDLE_NS + FHC_CLK_NS - 1) / FHC_CLK_NS;
    localparam int FHC_CYC_RDY_A = (FHC_T_RDY_ALG_NS + FHC_CLK_NS - 1) / FHC_CLK_NS;
    localparam int FHC_CYC_RSP   = (FHC_T_RSP_NS + FHC_CLK_NS - 1) / FHC_CLK_NS;
    localparam int FHC_CYC_BUSY  = (FHC_T_BUSY_NS + FHC_CLK_NS - 1) / FHC_CLK_NS;
    localparam int FHC_CYC_ACC   = (FHC_T_ACC_NS + FHC_CLK_NS - 1) / FHC_CLK_NS;
    localparam int FHC_CNT_W     = 13;

    // Bit positions of the toggle bits in the status word
    localparam int FHC_BIT_GTOG  = 6;
    localparam int FHC_BIT_ETOG  = 2;

    // Flash pin group driven by the controller
    typedef struct packed {
        logic        ce_n;
        logic        oe_n;
        logic        we_n;
        logic        clear_n;
        logic        unprot_hi;
        logic        word_sel;
        logic [19:0] addr;
    } fhc_pins_s;

    // Sequencer states
    typedef enum logic [3:0] {
        FHC_IDLE   = 4'b0000,
        FHC_W_LOW  = 4'b0001,
        FHC_W_HIGH = 4'b0010,
        FHC_R_ACC  = 4'b0011,
        FHC_R_END  = 4'b0100,
        FHC_C_LOW  = 4'b0101,
        FHC_C_WAIT = 4'b0110,
        FHC_C_HIGH = 4'b0111,
        FHC_P_RD1  = 4'b1000,
        FHC_P_GAP  = 4'b1001,
        FHC_P_RD2  = 4'b1010,
        FHC_U_SET  = 4'b1011,
        FHC_B_WAIT = 4'b1100
    } fhc_state_e;
endpackage

// file: fhc_pin_sync.sv
// Two-flop synchroniser for pins coming from the flash
`timescale 1ns/1ps
module fhc_pin_sync #(
    parameter int W = 1
) (
    // Clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // Pin in, synchronised out
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_sync
);
    logic [W-1:0] stage1;
    logic [W-1:0] next_stage1;
    logic [W-1:0] next_sync;

    // Straight pass; stage1 feeds only the second flop
    always_comb begin
        next_stage1 = pin_in;
        next_sync   = stage1;
    end

    // Register both stages
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            stage1   <= '0;
            pin_sync <= '0;
        end else begin
            stage1   <= next_stage1;
            pin_sync <= next_sync;
        end
    end
endmodule

// file: fhc_ctrl.sv
// Flash host controller: AHB-Lite registers and pin sequencer
`timescale 1ns/1ps
//////////////////////////////////////////////////////////////////////////////
module fhc_ctrl
    import fhc_pkg::*;
(
    // Clock and reset
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic      [31:0] hrdata,
    // Flash pins
    output fhc_pkg::fhc_pins_s pins,
    input  wire logic [15:0] dq_in,
    output logic      [15:0] dq_out,
    output logic             dq_oe_n,
    input  wire logic        busy_indicator_n,
    // Interrupt
    output logic             irq
);
    import fhc_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    logic [16:0] sync_in;
    logic [15:0] dq_s;
    logic [15:0] dq_w;
    logic        busy_s;

    fhc_pin_sync #(.W(17)) u_sync (
        .hclk     (hclk),
        .hresetn  (hresetn),
        .pin_in   ({~busy_indicator_n, dq_in}),
        .pin_sync (sync_in)
    );
    // Busy enters inverted, so the flops reset to not busy and no false ready follows reset
    assign dq_s   = sync_in[15:0];
    assign busy_s = sync_in[16];

    //////////////////////////////////////////////////////////////////////////
    // Byte mode: the upper lane carries no data, so it reads as zero
    assign dq_w   = pins.word_sel ? dq_s : {8'h00, dq_s[7:0]};

    //////////////////////////////////////////////////////////////////////////
    // State
    fhc_state_e             state, next_state;
    logic [FHC_CNT_W-1:0]   cnt, next_cnt;
    logic [2:0]             cfg, next_cfg;
    logic [19:0]            addr_r, next_addr_r;
    logic [15:0]            wdata_r, next_wdata_r;
    logic [15:0]            rdata_r, next_rdata_r;
    logic [15:0]            first_r, next_first_r;
    logic [2:0]             stat, next_stat;
    logic [2:0]             mask, next_mask;
    logic                   poll_fail, next_poll_fail;
    logic                   busy_d, next_busy_d;
    logic                   word_d, next_word_d;
    fhc_pins_s              next_pins;
    logic [15:0]            next_dq_out;
    logic                   next_dq_oe_n;
    logic                   wr_ph, next_wr_ph;
    logic [7:0]             wa, next_wa;
    logic [31:0]            next_hrdata;
    logic [2:0]             ev;
    logic                   bus_wr;
    logic [31:0]            rd_mux;
    logic                   run_cmd;

    //////////////////////////////////////////////////////////////////////////
    // Bus slave; always zero wait states, OKAY answers
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign bus_wr    = wr_ph;
    assign irq       = |(stat & mask);
    assign run_cmd   = bus_wr && (wa == FHC_REG_CTRL) && (state == FHC_IDLE);

    // Read mux, unmapped reads give zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (haddr)
            FHC_REG_CTRL:   rd_mux = 32'h0000_0000;
            FHC_REG_ADDR:   rd_mux = {12'h000, addr_r};
            FHC_REG_WDATA:  rd_mux = {16'h0000, wdata_r};
            FHC_REG_RDATA:  rd_mux = {16'h0000, rdata_r};
            FHC_REG_STATUS: rd_mux = {29'h0, poll_fail, busy_s, state != FHC_IDLE};
            FHC_REG_IRQ:    rd_mux = {29'h0, stat};
            FHC_REG_MASK:   rd_mux = {29'h0, mask};
            FHC_REG_CFG:    rd_mux = {29'h0, cfg};
            default:        rd_mux = 32'h0000_0000;
        endcase
    end

    // Address-phase capture and register updates
    always_comb begin
        next_wr_ph  = hsel && hready && htrans[1] && hwrite;
        next_wa     = haddr;
        next_hrdata = (hsel && hready && htrans[1] && !hwrite) ? rd_mux : hrdata;
        next_cfg    = cfg;
        next_mask   = mask;
        next_addr_r = addr_r;
        next_wdata_r = wdata_r;
        // Writes land at the data-phase edge, one cycle after the address
        if (bus_wr) begin
            case (wa)
                FHC_REG_ADDR:  next_addr_r  = hwdata[19:0];
                FHC_REG_WDATA: next_wdata_r = hwdata[15:0];
                FHC_REG_MASK:  next_mask    = hwdata[2:0];
                FHC_REG_CFG:   next_cfg     = hwdata[2:0];
                default:       next_cfg     = cfg;
            endcase
        end
        // Set wins over write-one-to-clear
        next_stat = stat;
        if (bus_wr && wa == FHC_REG_IRQ) begin
            next_stat = stat & ~hwdata[2:0];
        end
        next_stat = next_stat | ev;
    end

    // Bus-side registers; CTRL is not stored, it only starts the sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph   <= 1'b0;
            wa      <= 8'h00;
            hrdata  <= 32'h0000_0000;
            cfg     <= FHC_CFG_RESET;
            mask    <= FHC_MASK_RESET;
            addr_r  <= 20'h00000;
            wdata_r <= 16'h0000;
            stat    <= 3'h0;
        end else begin
            wr_ph   <= next_wr_ph;
            wa      <= next_wa;
            hrdata  <= next_hrdata;
            cfg     <= next_cfg;
            mask    <= next_mask;
            addr_r  <= next_addr_r;
            wdata_r <= next_wdata_r;
            stat    <= next_stat;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Pin sequencer
    always_comb begin
        // Defaults hold pins other than unprot_hi, and outputs; the counter runs down and stops at zero
        next_state     = state;
        next_cnt       = (cnt != '0) ? cnt - 1'b1 : cnt;
        next_pins      = pins;
        next_dq_out    = dq_out;
        next_dq_oe_n   = dq_oe_n;
        next_rdata_r   = rdata_r;
        next_first_r   = first_r;
        next_poll_fail = poll_fail;
        next_busy_d    = busy_s;
        next_word_d    = cfg[FHC_CFG_WORD];
        ev             = 3'h0;
        next_pins.unprot_hi = cfg[FHC_CFG_UNPROT] || (state == FHC_U_SET);
        // Busy release: next access allowed at once
        if (busy_d && !busy_s) begin
            ev[FHC_EV_READY] = 1'b1;
        end
        case (state)
            // Idle: all strobes high, data bus released
            FHC_IDLE: begin
                next_pins.ce_n = 1'b1;
                next_pins.oe_n = 1'b1;
                next_pins.we_n = 1'b1;
                next_dq_oe_n   = 1'b1;
                // Width pin moves only between accesses, never inside one
                next_pins.word_sel = cfg[FHC_CFG_WORD];
                if (run_cmd) begin
                    // Priority: clear, unprotect setup, write, then read or poll
                    next_pins.addr = addr_r;
                    if (hwdata[FHC_CTRL_CLEAR]) begin
                        next_pins.clear_n = 1'b0;
                        next_cnt   = FHC_CNT_W'(FHC_CYC_RP);
                        next_state = FHC_C_LOW;
                    end else if (hwdata[FHC_CTRL_UNPROT]) begin
                        next_pins.unprot_hi = 1'b1;
                        next_cnt   = FHC_CNT_W'(FHC_CYC_RSP);
                        next_state = FHC_U_SET;
                    end else if (hwdata[FHC_CTRL_WRITE]) begin
                        next_pins.ce_n = 1'b0;
                        next_pins.we_n = 1'b0;
                        next_dq_out    = cfg[FHC_CFG_WORD] ? wdata_r : {8'h00, wdata_r[7:0]};
                        next_dq_oe_n   = 1'b0;
                        next_cnt   = FHC_CNT_W'(FHC_CYC_WP);
                        next_state = FHC_W_LOW;
                    end else if (hwdata[FHC_CTRL_READ] || hwdata[FHC_CTRL_POLL]) begin
                        next_pins.ce_n = 1'b0;
                        next_pins.oe_n = 1'b0;
                        next_poll_fail = 1'b0;
                        // Word switch needs the longer access delay
                        next_cnt   = FHC_CNT_W'(FHC_CYC_ACC + 2);
                        next_state = hwdata[FHC_CTRL_POLL] ? FHC_P_RD1 : FHC_R_ACC;
                    end
                end
            end
            // Elevated level held for the setup time before any write
            FHC_U_SET: if (cnt == '0) begin
                ev[FHC_EV_DONE] = 1'b1;
                next_state = FHC_IDLE;
            end
            // Strobe low for the pulse width, data driven
            FHC_W_LOW: if (cnt == '0) begin
                next_pins.we_n = 1'b1;
                next_cnt   = FHC_CNT_W'(FHC_CYC_CYCLE - FHC_CYC_WP);
                next_state = FHC_W_HIGH;
            end
            // Rest of the cycle with strobe high, select still low
            FHC_W_HIGH: if (cnt == '0) begin
                next_pins.ce_n = 1'b1;
                next_dq_oe_n   = 1'b1;
                // Gap keeps strobe high before any next pulse
                next_cnt   = FHC_CNT_W'(FHC_CYC_WPH + FHC_CYC_BUSY + 2);
                next_state = FHC_B_WAIT;
            end
            // Busy pin may take this long to fall; no new strobe before it
            FHC_B_WAIT: if (cnt == '0) begin
                ev[FHC_EV_DONE] = 1'b1;
                next_state = FHC_IDLE;
            end
            // Access time over: take data through the synchroniser
            FHC_R_ACC, FHC_P_RD1, FHC_P_RD2: if (cnt == '0) begin
                next_pins.ce_n = 1'b1;
                next_pins.oe_n = 1'b1;
                // Data sampled through the synchroniser, stable by now
                next_cnt = FHC_CNT_W'(FHC_CYC_WPH);
                if (state == FHC_R_ACC) begin
                    next_rdata_r = dq_w;
                    next_state   = FHC_R_END;
                end else if (state == FHC_P_RD1) begin
                    // Strobe-split polls keep select low through the gap
                    next_pins.ce_n = cfg[FHC_CFG_CE_TOG];
                    next_first_r = dq_w;
                    next_state   = FHC_P_GAP;
                end else begin
                    next_rdata_r = dq_w;
                    // Equal toggle bit 6 in both reads means the algorithm is over
                    if (dq_s[FHC_BIT_GTOG] == first_r[FHC_BIT_GTOG]) begin
                        ev[FHC_EV_POLL_OK] = 1'b1;
                    end else begin
                        next_poll_fail = 1'b1;
                    end
                    next_state = FHC_R_END;
                end
            end
            // Gap between the two status reads
            FHC_P_GAP: if (cnt == '0) begin
                // Split reads by select or by read strobe only
                next_pins.ce_n = 1'b0;
                next_pins.oe_n = 1'b0;
                next_cnt   = FHC_CNT_W'(FHC_CYC_CYCLE + 2);
                next_state = FHC_P_RD2;
            end else if (!cfg[FHC_CFG_CE_TOG]) begin
                next_pins.ce_n = 1'b0;
            end
            // Select high time before the done event
            FHC_R_END: if (cnt == '0) begin
                ev[FHC_EV_DONE] = 1'b1;
                next_state = FHC_IDLE;
            end
            // Clear pulse low for its minimum width
            FHC_C_LOW: if (cnt == '0) begin
                next_pins.clear_n = 1'b1;
                // Wait covers both the idle and the algorithm case
                next_cnt   = busy_s ? FHC_CNT_W'(FHC_CYC_RDY_A)
                                    : FHC_CNT_W'(FHC_CYC_RDY_I);
                next_state = FHC_C_WAIT;
            end
            // Recovery, long if an algorithm was aborted
            FHC_C_WAIT: if (cnt == '0) begin
                next_cnt   = FHC_CNT_W'(FHC_CYC_RH);
                next_state = FHC_C_HIGH;
            end
            // Clear high before the first read
            FHC_C_HIGH: if (cnt == '0) begin
                ev[FHC_EV_DONE] = 1'b1;
                next_state = FHC_IDLE;
            end
            default: next_state = FHC_IDLE;
        endcase
    end

    // Register the sequencer
    // Reset drives every strobe high, so the flash sees no access meanwhile
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state     <= FHC_IDLE;
            cnt       <= '0;
            pins      <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, clear_n: 1'b1,
                           unprot_hi: 1'b0, word_sel: 1'b1, addr: 20'h00000};
            dq_out    <= 16'h0000;
            dq_oe_n   <= 1'b1;
            rdata_r   <= 16'h0000;
            first_r   <= 16'h0000;
            poll_fail <= 1'b0;
            busy_d    <= 1'b0;
            word_d    <= 1'b1;
        end else begin
            state     <= next_state;
            cnt       <= next_cnt;
            pins      <= next_pins;
            dq_out    <= next_dq_out;
            dq_oe_n   <= next_dq_oe_n;
            rdata_r   <= next_rdata_r;
            first_r   <= next_first_r;
            poll_fail <= next_poll_fail;
            busy_d    <= next_busy_d;
            word_d    <= next_word_d;
        end
    end
endmodule

// file: fhc_checker.sv
// Checker: flash pin timing of the host controller
`timescale 1ns/1ps
module fhc_checker
    import fhc_pkg::*;
(
    // Clock and reset
    input wire logic               hclk,
    input wire logic               hresetn,
    // Flash side
    input wire fhc_pkg::fhc_pins_s pins,
    input wire logic               dq_oe_n,
    input wire logic               busy_indicator_n
);
    logic [12:0] ce_cnt;
    logic [12:0] clr_cnt;
    logic [12:0] unp_cnt;
    logic [12:0] next_ce_cnt;
    logic [12:0] next_clr_cnt;
    logic [12:0] next_unp_cnt;

    // Low time of select and clear, held time of unprotect level
    always_comb begin
        next_ce_cnt  = pins.ce_n ? 13'h0000 : ce_cnt + 13'h0001;
        next_clr_cnt = pins.clear_n ? 13'h0000 : clr_cnt + 13'h0001;
        next_unp_cnt = !pins.unprot_hi ? 13'h0000 : unp_cnt + {12'h000, unp_cnt != 13'h1FFF};
    end

    // Saturating unprotect count avoids a wrap on long holds
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ce_cnt  <= 13'h0000;
            clr_cnt <= 13'h0000;
            unp_cnt <= 13'h0000;
        end else begin
            ce_cnt  <= next_ce_cnt;
            clr_cnt <= next_clr_cnt;
            unp_cnt <= next_unp_cnt;
        end
    end

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    ////////////////////////////////////////////////////////////////////////////
    sequence strobe_high_s;
        pins.we_n [*4];
    endsequence
    sequence pulse_low_s;
        !pins.we_n [*8] ##1 !pins.we_n [*2];
    endsequence
    sequence read_idle_s;
        pins.oe_n [*8] ##1 pins.oe_n [*2];
    endsequence

    wph_hold_a: assert property ($rose(pins.we_n) |-> strobe_high_s)
        else $error("write strobe high time too short");
    wp_width_a: assert property ($fell(pins.we_n) |-> pulse_low_s)
        else $error("write pulse too short");
    cycle_len_a: assert property ($rose(pins.ce_n) |-> ce_cnt >= FHC_CYC_CYCLE)
        else $error("bus cycle too short");
    rh_read_a: assert property ($rose(pins.clear_n) |-> read_idle_s)
        else $error("read too soon after clear");
    rp_width_a: assert property ($rose(pins.clear_n) |-> clr_cnt >= FHC_CYC_RP)
        else $error("clear pulse too short");
    unprot_setup_a: assert property ($fell(pins.we_n) && pins.unprot_hi |-> unp_cnt >= FHC_CYC_RSP)
        else $error("write too soon after unprotect level");
    busy_write_a: assert property ($fell(pins.we_n) |-> busy_indicator_n && $past(busy_indicator_n, 4))
        else $error("write issued while flash busy");
    data_drive_a: assert property (!pins.we_n |-> !dq_oe_n && !pins.ce_n)
        else $error("data not driven during write pulse");
endmodule

bind fhc_ctrl fhc_checker fhc_checker_i (.hclk(hclk), .hresetn(hresetn), .pins(pins), .dq_oe_n(dq_oe_n),
    .busy_indicator_n(busy_indicator_n));

// file: fhc_flash_model.sv
// Behavioural flash device facing the controller pins
`timescale 1ns/1ps
module fhc_flash_model
    import fhc_pkg::*;
#(
    parameter int BUSY_NS = 3000
) (
    // Controller pins and the bench scenario kick
    input  wire fhc_pkg::fhc_pins_s pins,
    input  wire logic [15:0]        dq_out,
    input  wire logic               dq_oe_n,
    input  wire logic               kick,
    // Device outputs
    output logic [15:0]             dq_in,
    output logic                    busy_indicator_n
);
    logic [15:0] mem = 16'h0000;
    logic [15:0] last = 16'h0000;
    logic [15:0] word;
    logic        tog = 1'b0;
    logic        sel;

    // Status word while busy, toggles at bits 6 and 2, any address
    assign sel = !pins.ce_n && !pins.oe_n;
    assign word = !busy_indicator_n ? {9'h000, tog, 3'h0, tog, 2'h0} : mem;
    // Off bus shows the inverse of the last value, never a stale copy
    assign dq_in = sel ? {pins.word_sel ? word[15:8] : ~last[15:8], word[7:0]} : ~last;

    initial busy_indicator_n = 1'b1;

    // Each read start while busy flips the toggle bits, by strobe or by select
    always @(posedge sel) begin
        if (!busy_indicator_n) tog = ~tog;
        last = word;
    end

    // Latch program data and go busy shortly after the last write
    always @(posedge pins.we_n) if (!pins.ce_n && !dq_oe_n) begin
        mem = dq_out;
        #30 busy_indicator_n = 1'b0;
    end

    // Scenario hook: an operation already running
    always @(posedge kick) busy_indicator_n = 1'b0;

    // Length is variable; only the pin tells completion
    always @(negedge busy_indicator_n) begin : run
        #(BUSY_NS) busy_indicator_n = 1'b1;
    end

    // Clear aborts a running algorithm; idle clear needs no recovery
    always @(negedge pins.clear_n) if (!busy_indicator_n) begin
        disable run;
        tog = 1'b0;
        #2000 busy_indicator_n = 1'b1;
    end
endmodule

// file: fhc_ctrl_bench.sv
// Testbench: register-driven tests of the flash host controller
`timescale 1ns/1ps
module fhc_ctrl_bench;
    import fhc_pkg::*;
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic        hwrite = 1'b0;
    logic        kick = 1'b0;
    logic [7:0]  haddr = 8'h00;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic        hreadyout;
    logic        hresp;
    logic        irq;
    logic        dq_oe_n;
    logic        busy_indicator_n;
    logic [15:0] dq_in;
    logic [15:0] dq_out;
    fhc_pins_s   pins;
    int          bad_count = 0;
    int          cmp_count = 0;
    int          k;
    int          m;
    time         t0;

    always #2.5 hclk = ~hclk;

    fhc_ctrl fhc_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .pins(pins), .dq_in(dq_in), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .busy_indicator_n(busy_indicator_n), .irq(irq));
    fhc_flash_model #(.BUSY_NS(3000)) fhc_flash_model_i (.pins(pins), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
        .kick(kick), .dq_in(dq_in), .busy_indicator_n(busy_indicator_n));

    ////////////////////////////////////////////////////////////////////////////
    // One AHB-Lite single word transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd = hrdata;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    // Bounded wait on the sequencer busy bit
    task automatic wait_done;
        rd = 32'h1;
        for (k = 0; k < 3000 && rd[FHC_ST_BUSY] !== 1'b0; k++) bus(1'b0, FHC_REG_STATUS, 32'h0);
        chk(rd[FHC_ST_BUSY], 32'h0);
    endtask

    // Bounded wait on the flash busy pin as seen in STATUS
    task automatic wait_dev;
        rd = 32'h2;
        for (k = 0; k < 3000 && rd[FHC_ST_DEV_BUSY] !== 1'b0; k++) bus(1'b0, FHC_REG_STATUS, 32'h0);
        chk(rd[FHC_ST_DEV_BUSY], 32'h0);
    endtask

    task automatic end_sim;
        $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // Whole run is under 10000 cycles; this is four times that
    initial begin
        #200000;
        bad_count++;
        $display("Error at %0t: watchdog expired", $time);
        end_sim();
    end

    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rchk(FHC_REG_CFG, 32'h1);
        rchk(FHC_REG_MASK, 32'h0);
        rchk(8'h20, 32'h0);
        rchk(FHC_REG_IRQ, 32'h0);
        chk({pins.clear_n, pins.unprot_hi, hresp}, 32'h4);
        $display("Test reset done");
        // Program, with a read refused mid-operation
        bus(1'b1, FHC_REG_MASK, 32'h7);
        bus(1'b1, FHC_REG_ADDR, 32'h12345);
        bus(1'b1, FHC_REG_WDATA, 32'hBEEF);
        bus(1'b1, FHC_REG_CTRL, 32'h1);
        bus(1'b1, FHC_REG_CTRL, 32'h2);
        wait_done();
        wait_dev();
        rchk(FHC_REG_IRQ, 32'h5);
        chk(irq, 32'h1);
        rchk(FHC_REG_RDATA, 32'h0);
        bus(1'b1, FHC_REG_IRQ, 32'h7);
        rchk(FHC_REG_IRQ, 32'h0);
        chk(irq, 32'h0);
        bus(1'b1, FHC_REG_CTRL, 32'h2);
        wait_done();
        rchk(FHC_REG_RDATA, 32'hBEEF);
        bus(1'b1, FHC_REG_CFG, 32'h0);
        bus(1'b1, FHC_REG_CTRL, 32'h2);
        wait_done();
        rchk(FHC_REG_RDATA, 32'h00EF);
        $display("Test program done");
        // Polls during busy, split by strobe then by select, same sector
        for (m = 0; m < 2; m++) begin
            bus(1'b1, FHC_REG_CFG, {30'h0, m[0], 1'b1});
            kick <= 1'b1;
            bus(1'b1, FHC_REG_CTRL, 32'h8);
            kick <= 1'b0;
            wait_done();
            rchk(FHC_REG_STATUS, 32'h6);
        end
        // Clear in mid-algorithm must wait the long recovery
        t0 = $time;
        bus(1'b1, FHC_REG_CTRL, 32'h4);
        wait_done();
        chk($time - t0 >= 20000, 32'h1);
        rchk(FHC_REG_STATUS, 32'h4);
        bus(1'b1, FHC_REG_IRQ, 32'h7);
        bus(1'b1, FHC_REG_CTRL, 32'h8);
        wait_done();
        chk(rd[FHC_ST_POLL_FAIL], 32'h0);
        rchk(FHC_REG_IRQ, 32'h3);
        // Idle clear takes the short recovery only
        t0 = $time;
        bus(1'b1, FHC_REG_CTRL, 32'h4);
        wait_done();
        chk($time - t0 >= 500 && $time - t0 < 20000, 32'h1);
        $display("Test poll and clear done");
        // Unprotect setup then a program under the raised level
        bus(1'b1, FHC_REG_CFG, 32'h5);
        bus(1'b1, FHC_REG_CTRL, 32'h10);
        wait_done();
        bus(1'b1, FHC_REG_CTRL, 32'h1);
        wait_done();
        chk(pins.unprot_hi, 32'h1);
        // Interrupt masked, unmasked, cleared
        bus(1'b1, FHC_REG_IRQ, 32'h7);
        bus(1'b1, FHC_REG_MASK, 32'h0);
        bus(1'b1, FHC_REG_CTRL, 32'h2);
        wait_done();
        chk(irq, 32'h0);
        bus(1'b1, FHC_REG_MASK, 32'h1);
        rchk(FHC_REG_MASK, 32'h1);
        chk(irq, 32'h1);
        bus(1'b1, FHC_REG_IRQ, 32'h1);
        rchk(FHC_REG_IRQ, 32'h0);
        chk(irq, 32'h0);
        $display("Test unprotect and interrupt done");
        end_sim();
    end
endmodule
